// file: logic/sec_arb_pkg.sv
package sec_arb_pkg;

   // Configuration byte offsets.
   localparam logic [7:0] OFF_BRIDGE_CONTROL   = 8'h40;
   localparam logic [7:0] OFF_ARBITER_CONTROL  = 8'h43;
   localparam logic [7:0] OFF_SEC_SPLIT_LO     = 8'h44;
   localparam logic [7:0] OFF_SEC_SPLIT_HI     = 8'h45;
   localparam logic [7:0] OFF_PRI_SPLIT_LO     = 8'h46;
   localparam logic [7:0] OFF_PRI_SPLIT_HI     = 8'h47;
   localparam logic [7:0] OFF_DMA_REQ_CONTROL  = 8'h48;
   localparam logic [7:0] OFF_EXTRA_PRIORITY   = 8'h49;
   localparam logic [7:0] OFF_CLOCK_OUT_ENABLE = 8'h4A;

   // Reset values, reserved bits included.
   localparam logic [7:0]  RST_BRIDGE_CONTROL   = 8'h04;
   localparam logic [7:0]  RST_ARBITER_CONTROL  = 8'hFF;
   localparam logic [15:0] RST_SPLIT_COUNT      = 16'h0000;
   localparam logic [7:0]  RST_DMA_REQ_CONTROL  = 8'h08;
   localparam logic [7:0]  RST_EXTRA_PRIORITY   = 8'h0F;
   localparam logic [7:0]  RST_CLOCK_OUT_ENABLE = 8'h3F;

   // Writable bit masks; other bits hold their reset value.
   localparam logic [7:0] WMASK_BRIDGE_CONTROL   = 8'h2E;
   localparam logic [7:0] WMASK_ARBITER_CONTROL  = 8'h80;
   localparam logic [7:0] WMASK_DMA_REQ_CONTROL  = 8'h0F;
   localparam logic [7:0] WMASK_EXTRA_PRIORITY   = 8'h02;
   localparam logic [7:0] WMASK_CLOCK_OUT_ENABLE = 8'h0F;

   // Field positions.
   localparam int BIT_LOCK_FORWARD   = 2;
   localparam int BIT_LOCK_STATE_LO  = 6;
   localparam int BIT_ARBITER_ON     = 7;
   localparam int BIT_DMA_REQ3_ON    = 0;
   localparam int BIT_DMA_REQ4_ON    = 1;
   localparam int BIT_FBB_RETRY_ON   = 2;
   localparam int BIT_LOCK_OP_ON     = 3;
   localparam int BIT_DMA_PRIORITY   = 1;

   // Request lines that may carry DMA-capable devices.
   localparam int DMA_REQ_A = 3;
   localparam int DMA_REQ_B = 4;

   // Arbiter states.
   typedef enum logic [0:0] {
      ARB_IDLE = 1'b0,
      ARB_BUSY = 1'b1
   } arb_state_t;

endpackage : sec_arb_pkg

// file: logic/sec_arb_grant.sv
`timescale 1ns/1ps
module sec_arb_grant
   import sec_arb_pkg::*;
#(
   parameter int N = 8
) (
   // Clock and reset.
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   // Control.
   input  wire logic         i_enable,
   input  wire logic [N-1:0] i_req,
   input  wire logic [N-1:0] i_hi,
   // Grant, one-hot or all zero, from a register.
   output logic      [N-1:0] o_gnt
);
   localparam int IW = $clog2(N);

   arb_state_t     state_q, state_d;
   logic [N-1:0]   gnt_q, gnt_d;
   logic [IW-1:0]  last_q, last_d;
   logic           found;
   logic [IW-1:0]  pick;

   // Picks the next requester: the high group first, then everyone, both rotating past the last winner.
   always_comb begin
      int idx;
      idx   = 0;
      found = 1'b0;
      pick  = '0;
      for (int i = 0; i < N; i++) begin
         idx = (int'(last_q) + 1 + i) % N;
         if (!found && i_req[idx] && i_hi[idx]) begin
            found = 1'b1;
            pick  = IW'(idx);
         end
      end
      for (int i = 0; i < N; i++) begin
         idx = (int'(last_q) + 1 + i) % N;
         if (!found && i_req[idx]) begin
            found = 1'b1;
            pick  = IW'(idx);
         end
      end
   end

   // Grant sequencing: one owner at a time, with an idle cycle between owners except when i_enable changes.
   always_comb begin
      state_d = state_q;
      gnt_d   = gnt_q;
      last_d  = last_q;
      if (!i_enable) begin
         state_d = ARB_IDLE;
         gnt_d   = '0;
         gnt_d[N-1] = 1'b1;
      end else begin
         unique case (state_q)
            ARB_IDLE: begin
               gnt_d = '0;
               if (found) begin
                  gnt_d[pick] = 1'b1;
                  last_d      = pick;
                  state_d     = ARB_BUSY;
               end
            end
            ARB_BUSY: begin
               if ((gnt_q & i_req) == '0) begin
                  gnt_d   = '0;
                  state_d = ARB_IDLE;
               end
            end
         endcase
      end
   end

   // Arbiter registers; after reset no master holds a grant.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ARB_IDLE;
         gnt_q   <= '0;
         last_q  <= '0;
      end else begin
         state_q <= state_d;
         gnt_q   <= gnt_d;
         last_q  <= last_d;
      end
   end

   assign o_gnt = gnt_q;

endmodule : sec_arb_grant

// file: logic/sec_arb_ctrl.sv
`timescale 1ns/1ps
module sec_arb_ctrl
   import sec_arb_pkg::*;
#(
   parameter int NREQ = 7
) (
   // Clock and reset.
   input  wire logic            i_clk,
   input  wire logic            i_rstn,
   // Configuration space byte port.
   input  wire logic [7:0]      i_cfg_addr,
   input  wire logic            i_cfg_wr,
   input  wire logic [7:0]      i_cfg_wdata,
   input  wire logic            i_cfg_rd,
   output logic      [7:0]      o_cfg_rdata,
   // Secondary bus request and grant pins, active low.
   input  wire logic [NREQ-1:0] i_req_n,
   output logic      [NREQ-1:0] o_gnt_n,
   // Bridge master request and grant.
   input  wire logic            i_bridge_master_req,
   output logic                 o_bridge_master_gnt,
   // Burst split events from the master latency timers.
   input  wire logic            i_sec_split,
   input  wire logic            i_pri_split,
   // Fast back-to-back retry.
   input  wire logic            i_fbb_cycle,
   input  wire logic            i_wbuf_full,
   output logic                 o_fbb_retry,
   // Lock handling.
   input  wire logic [1:0]      i_lock_state,
   output logic                 o_lock_forward_on,
   // Secondary clock output gates for outputs 4 to 7.
   output logic      [3:0]      o_clock_out_on,
   // DMA-capable flags for requests 3 and 4.
   output logic      [1:0]      o_dma_capable_requester
);

   logic [7:0]      bridge_control_q, bridge_control_d;
   logic [7:0]      arbiter_control_q, arbiter_control_d;
   logic [7:0]      dma_control_q, dma_control_d;
   logic [7:0]      extra_priority_q, extra_priority_d;
   logic [7:0]      clock_enable_q, clock_enable_d;
   logic [15:0]     secondary_split_count_q, secondary_split_count_d;
   logic [15:0]     primary_split_count_q, primary_split_count_d;
   logic [7:0]      rdata_q, rdata_d;
   logic [NREQ-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [NREQ-1:0] req_q, req_d;
   logic [NREQ-1:0] agree;
   logic [NREQ:0]   arb_req, arb_hi, arb_gnt;
   logic            arbiter_on;
   logic            dma_prio;

   // Masked byte write: writable bits take the data, the rest keep their value.
   function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [7:0] data,
                                          input logic [7:0] mask);
      wr_byte = (cur & ~mask) | (data & mask);
   endfunction : wr_byte

   // Control register writes.
   always_comb begin
      bridge_control_d  = bridge_control_q;
      arbiter_control_d = arbiter_control_q;
      dma_control_d     = dma_control_q;
      extra_priority_d  = extra_priority_q;
      clock_enable_d    = clock_enable_q;
      if (i_cfg_wr) begin
         unique case (i_cfg_addr)
            OFF_BRIDGE_CONTROL:
               bridge_control_d = wr_byte(bridge_control_q, i_cfg_wdata, WMASK_BRIDGE_CONTROL);
            OFF_ARBITER_CONTROL:
               arbiter_control_d = wr_byte(arbiter_control_q, i_cfg_wdata, WMASK_ARBITER_CONTROL);
            OFF_DMA_REQ_CONTROL:
               dma_control_d = wr_byte(dma_control_q, i_cfg_wdata, WMASK_DMA_REQ_CONTROL);
            OFF_EXTRA_PRIORITY:
               extra_priority_d = wr_byte(extra_priority_q, i_cfg_wdata, WMASK_EXTRA_PRIORITY);
            OFF_CLOCK_OUT_ENABLE:
               clock_enable_d = wr_byte(clock_enable_q, i_cfg_wdata, WMASK_CLOCK_OUT_ENABLE);
            default: begin
            end
         endcase
      end
   end

   // Control registers, reset to their defaults.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bridge_control_q  <= RST_BRIDGE_CONTROL;
         arbiter_control_q <= RST_ARBITER_CONTROL;
         dma_control_q     <= RST_DMA_REQ_CONTROL;
         extra_priority_q  <= RST_EXTRA_PRIORITY;
         clock_enable_q    <= RST_CLOCK_OUT_ENABLE;
      end else begin
         bridge_control_q  <= bridge_control_d;
         arbiter_control_q <= arbiter_control_d;
         dma_control_q     <= dma_control_d;
         extra_priority_q  <= extra_priority_d;
         clock_enable_q    <= clock_enable_d;
      end
   end

   // Split counters: a written byte is loaded, otherwise each split event counts and wraps.
   always_comb begin
      secondary_split_count_d = secondary_split_count_q;
      primary_split_count_d   = primary_split_count_q;
      if (i_sec_split) begin
         secondary_split_count_d = secondary_split_count_q + 16'h0001;
      end
      if (i_pri_split) begin
         primary_split_count_d = primary_split_count_q + 16'h0001;
      end
      if (i_cfg_wr) begin
         unique case (i_cfg_addr)
            OFF_SEC_SPLIT_LO: secondary_split_count_d[7:0]  = i_cfg_wdata;
            OFF_SEC_SPLIT_HI: secondary_split_count_d[15:8] = i_cfg_wdata;
            OFF_PRI_SPLIT_LO: primary_split_count_d[7:0]    = i_cfg_wdata;
            OFF_PRI_SPLIT_HI: primary_split_count_d[15:8]   = i_cfg_wdata;
            default: begin
            end
         endcase
      end
   end

   // Split counter registers.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         secondary_split_count_q <= RST_SPLIT_COUNT;
         primary_split_count_q   <= RST_SPLIT_COUNT;
      end else begin
         secondary_split_count_q <= secondary_split_count_d;
         primary_split_count_q   <= primary_split_count_d;
      end
   end

   // Read data, registered one cycle after the read strobe; unmapped offsets read zero.
   always_comb begin
      rdata_d = rdata_q;
      if (i_cfg_rd) begin
         unique case (i_cfg_addr)
            OFF_BRIDGE_CONTROL:   rdata_d = {i_lock_state, bridge_control_q[BIT_LOCK_STATE_LO-1:0]};
            OFF_ARBITER_CONTROL:  rdata_d = arbiter_control_q;
            OFF_SEC_SPLIT_LO:     rdata_d = secondary_split_count_q[7:0];
            OFF_SEC_SPLIT_HI:     rdata_d = secondary_split_count_q[15:8];
            OFF_PRI_SPLIT_LO:     rdata_d = primary_split_count_q[7:0];
            OFF_PRI_SPLIT_HI:     rdata_d = primary_split_count_q[15:8];
            OFF_DMA_REQ_CONTROL:  rdata_d = dma_control_q;
            OFF_EXTRA_PRIORITY:   rdata_d = extra_priority_q;
            OFF_CLOCK_OUT_ENABLE: rdata_d = clock_enable_q;
            default:              rdata_d = 8'h00;
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Request pins pass three flops; a level counts once the second and third agree.
   assign agree = ~(pin_s2_q ^ pin_s3_q);

   always_comb begin
      req_d = (agree & ~pin_s3_q) | (~agree & req_q);
   end

   // Request synchroniser registers; idle pins sit high.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
         pin_s3_q <= '1;
         req_q    <= '0;
      end else begin
         pin_s1_q <= i_req_n;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         req_q    <= req_d;
      end
   end

   // Arbiter inputs: the bridge master is the top requester and always in the high group.
   assign arbiter_on = arbiter_control_q[BIT_ARBITER_ON];
   assign dma_prio   = extra_priority_q[BIT_DMA_PRIORITY];

   always_comb begin
      arb_req       = {i_bridge_master_req, req_q};
      arb_hi        = '0;
      arb_hi[NREQ]  = 1'b1;
      arb_hi[DMA_REQ_A] = dma_prio & dma_control_q[BIT_DMA_REQ3_ON];
      arb_hi[DMA_REQ_B] = dma_prio & dma_control_q[BIT_DMA_REQ4_ON];
   end

   sec_arb_grant #(
      .N        (NREQ + 1)
   ) u_grant (
      .i_clk    (i_clk),
      .i_rstn   (i_rstn),
      .i_enable (arbiter_on),
      .i_req    (arb_req),
      .i_hi     (arb_hi),
      .o_gnt    (arb_gnt)
   );

   // Outputs.
   assign o_gnt_n                 = ~arb_gnt[NREQ-1:0];
   assign o_bridge_master_gnt     = arb_gnt[NREQ];
   assign o_cfg_rdata             = rdata_q;
   assign o_fbb_retry             = dma_control_q[BIT_FBB_RETRY_ON] & i_fbb_cycle & i_wbuf_full;
   assign o_lock_forward_on       = bridge_control_q[BIT_LOCK_FORWARD] & dma_control_q[BIT_LOCK_OP_ON];
   assign o_clock_out_on          = clock_enable_q[3:0];
   assign o_dma_capable_requester = {dma_control_q[BIT_DMA_REQ4_ON], dma_control_q[BIT_DMA_REQ3_ON]};

endmodule : sec_arb_ctrl

// file: testbench/sec_arb_ctrl_assertions.sv
`timescale 1ns/1ps
module sec_arb_ctrl_assertions
   import sec_arb_pkg::*;
#(
   parameter int NREQ = 7
) (
   // Clock and reset.
   input wire logic            i_clk,
   input wire logic            i_rstn,
   // Register port.
   input wire logic [7:0]      i_cfg_addr,
   input wire logic            i_cfg_wr,
   input wire logic [7:0]      i_cfg_wdata,
   input wire logic            i_cfg_rd,
   input wire logic [7:0]      o_cfg_rdata,
   // Requests and grants.
   input wire logic [NREQ-1:0] i_req_n,
   input wire logic [NREQ-1:0] o_gnt_n,
   input wire logic            o_bridge_master_gnt,
   // Side functions.
   input wire logic            i_sec_split,
   input wire logic            i_pri_split,
   input wire logic            i_fbb_cycle,
   input wire logic            i_wbuf_full,
   input wire logic            o_fbb_retry,
   input wire logic            o_lock_forward_on,
   input wire logic [3:0]      o_clock_out_on,
   input wire logic [1:0]      o_dma_capable_requester
);
   logic [15:0] sec_q, sec_d, pri_q, pri_d;
   logic [7:0]  dma_q, dma_d, cnt_byte;
   logic [3:0]  cke_q, cke_d;
   logic        arb_q, arb_d, lk_q, lk_d;

   // Shadow of the writable state except extra priority and bridge control bits 1, 3 and 5, followed from register writes and split pulses.
   always_comb begin
      sec_d = sec_q + 16'(i_sec_split);
      pri_d = pri_q + 16'(i_pri_split);
      {arb_d, lk_d, dma_d, cke_d} = {arb_q, lk_q, dma_q, cke_q};
      if (i_cfg_wr) begin
         case (i_cfg_addr)
            8'h40: lk_d = i_cfg_wdata[2];
            8'h43: arb_d = i_cfg_wdata[7];
            8'h44: sec_d[7:0] = i_cfg_wdata;
            8'h45: sec_d[15:8] = i_cfg_wdata;
            8'h46: pri_d[7:0] = i_cfg_wdata;
            8'h47: pri_d[15:8] = i_cfg_wdata;
            8'h48: dma_d = {4'h0, i_cfg_wdata[3:0]};
            8'h4A: cke_d = i_cfg_wdata[3:0];
            default: ;
         endcase
      end
      cnt_byte = 8'({pri_q, sec_q} >> {i_cfg_addr[1:0], 3'h0});
   end

   // Registers of the shadow state.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         {sec_q, pri_q, dma_q, cke_q, arb_q, lk_q} <= {32'h0, 8'h08, 4'hF, 2'h3};
      end else begin
         {sec_q, pri_q, dma_q, cke_q, arb_q, lk_q} <= {sec_d, pri_d, dma_d, cke_d, arb_d, lk_d};
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   chk_one_grant: assert property ($onehot0({o_bridge_master_gnt, ~o_gnt_n}))
      else $error("more than one grant");
   chk_arb_off: assert property (!arb_q && !$past(arb_q) |=> &o_gnt_n && o_bridge_master_gnt)
      else $error("disabled arbiter granted another master");
   chk_grant_hold: assert property (arb_q && (o_gnt_n | i_req_n) != '1 |=> $stable(o_gnt_n))
      else $error("grant moved while requested");
   chk_grant_soon: assert property (arb_q && !o_bridge_master_gnt && &o_gnt_n && !(&i_req_n)
      |-> ##[1:8] (o_bridge_master_gnt || !(&o_gnt_n))) else $error("pending request not granted");
   chk_count_read: assert property (i_cfg_rd && i_cfg_addr[7:2] == 6'h11
      |=> o_cfg_rdata == $past(cnt_byte)) else $error("split count read wrong");
   chk_arb_read: assert property (i_cfg_rd && i_cfg_addr == 8'h43
      |=> o_cfg_rdata == {$past(arb_q), 7'h7F}) else $error("arbiter control read wrong");
   chk_fbb_retry: assert property (o_fbb_retry == (dma_q[2] && i_fbb_cycle && i_wbuf_full))
      else $error("retry output wrong");
   chk_dma_flags: assert property (o_dma_capable_requester == dma_q[1:0])
      else $error("dma flags wrong");
   chk_clock_gates: assert property (o_clock_out_on == cke_q)
      else $error("clock gates wrong");
   chk_lock_fwd: assert property (o_lock_forward_on == (lk_q && dma_q[3]))
      else $error("lock forwarding wrong");
endmodule : sec_arb_ctrl_assertions

bind sec_arb_ctrl sec_arb_ctrl_assertions #(.NREQ(NREQ)) u_sec_arb_ctrl_assertions (.*);

// file: testbench/sec_bus_agents.sv
`timescale 1ns/1ps
module sec_bus_agents #(
   parameter int NREQ = 7,
   parameter int HOLD = 4
) (
   // Clock, reset and test control.
   input  wire logic            i_clk,
   input  wire logic            i_rstn,
   input  wire logic [NREQ-1:0] i_want,
   // Request and grant pins, active low.
   input  wire logic [NREQ-1:0] i_gnt_n,
   output logic      [NREQ-1:0] o_req_n
);
   int cnt [NREQ];

   // Each agent asks when wanted, keeps asking through a burst once granted, then lets go.
   // A released pin stays high for at least HOLD+1 cycles, so the three-flop filter sees the release.
   always @(posedge i_clk or negedge i_rstn) begin
      for (int k = 0; k < NREQ; k++) begin
         if (!i_rstn) begin
            o_req_n[k] <= 1'b1;
            cnt[k] <= 0;
         end else if (o_req_n[k]) begin
            if (i_want[k] && cnt[k] >= HOLD) begin
               o_req_n[k] <= 1'b0;
               cnt[k] <= 0;
            end else if (cnt[k] < HOLD) begin
               cnt[k] <= cnt[k] + 1;
            end
         end else if (!i_gnt_n[k]) begin
            if (cnt[k] >= HOLD) begin
               o_req_n[k] <= 1'b1;
               cnt[k] <= 0;
            end else begin
               cnt[k] <= cnt[k] + 1;
            end
         end
      end
   end
endmodule : sec_bus_agents

// file: testbench/sec_arb_ctrl_bench.sv
`timescale 1ns/1ps
module sec_arb_ctrl_bench;
   import sec_arb_pkg::*;
   localparam int NREQ = 7;
   // Design ports and partner control.
   logic       i_clk, i_rstn, i_cfg_wr, i_cfg_rd, i_bridge_master_req, o_bridge_master_gnt;
   logic       i_sec_split, i_pri_split, i_fbb_cycle, i_wbuf_full, o_fbb_retry, o_lock_forward_on;
   logic [7:0] i_cfg_addr, i_cfg_wdata, o_cfg_rdata, ex, wd;
   logic [6:0] i_req_n, o_gnt_n, want;
   logic [1:0] i_lock_state, o_dma_capable_requester;
   logic [3:0] o_clock_out_on;
   int         n_errors, samples_checked, cyc;

   sec_arb_ctrl #(.NREQ(NREQ)) u_sec_arb_ctrl (.*);
   sec_bus_agents #(.NREQ(NREQ), .HOLD(4)) u_sec_bus_agents (.i_clk, .i_rstn, .i_want(want),
      .i_gnt_n(o_gnt_n), .o_req_n(i_req_n));

   // Clock of 100 ns.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // A hang ends the run as a failure.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {i_cfg_addr, i_cfg_wdata, i_cfg_wr} = {a, d, 1'b1};
      @(negedge i_clk);
      i_cfg_wr = 1'b0;
      @(negedge i_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      {i_cfg_addr, i_cfg_rd} = {a, 1'b1};
      @(negedge i_clk);
      i_cfg_rd = 1'b0;
      @(negedge i_clk);
      cmp(o_cfg_rdata, e, "read");
   endtask : rd

   // Bit 7 of the masks is the bridge master, bits 6:0 the agents.
   task automatic race(input logic [7:0] m, input logic [7:0] e);
      int t;
      {i_bridge_master_req, want} = m;
      for (t = 0; t < 40 && {o_bridge_master_gnt, ~o_gnt_n} == 8'h00; t++) @(negedge i_clk);
      cmp({o_bridge_master_gnt, ~o_gnt_n}, e, "first grant");
      want = '0;
      for (t = 0; t < 80 && {i_bridge_master_req, ~i_req_n, o_bridge_master_gnt, ~o_gnt_n} != '0; t++) begin
         if (o_bridge_master_gnt) i_bridge_master_req = 1'b0;
         @(negedge i_clk);
      end
      repeat (4) @(negedge i_clk);
   endtask : race

   // Writable mask in the high byte, reset value in the low byte.
   function automatic logic [15:0] reg_info(input logic [7:0] a);
      case (a)
         8'h40: return 16'h2E04;
         8'h43: return 16'h80FF;
         8'h44, 8'h45, 8'h46, 8'h47: return 16'hFF00;
         8'h48: return 16'h0F08;
         8'h49: return 16'h020F;
         8'h4A: return 16'h0F3F;
         default: return 16'h0000;
      endcase
   endfunction : reg_info

   // Main sequence.
   initial begin
      {i_rstn, i_cfg_wr, i_cfg_rd, i_bridge_master_req, i_sec_split, i_pri_split} = '0;
      {i_fbb_cycle, i_wbuf_full, i_cfg_addr, i_cfg_wdata, want} = '0;
      i_lock_state = 2'h2;
      repeat (16) @(negedge i_clk);
      i_rstn = 1'b1;
      for (int p = 0; p < 3; p++) begin
         for (int a = 8'h40; a < 8'h4C; a++) begin
            wd = (p == 1) ? 8'hFF : 8'h00;
            if (p > 0) wr(8'(a), wd);
            ex = (p == 0) ? reg_info(8'(a)) : (reg_info(8'(a)) & ~(reg_info(8'(a)) >> 8)) | (wd & 8'(reg_info(8'(a)) >> 8));
            if (a == 8'h40) ex[7:6] = i_lock_state;
            rd(8'(a), ex);
         end
         cmp({1'b0, o_lock_forward_on, o_clock_out_on, o_dma_capable_requester}, (p == 0) ? 8'h7C : (p == 1) ? 8'h7F : 8'h00, "outputs");
      end
      wr(8'h40, 8'h04);
      wr(8'h43, 8'h80);
      wr(8'h49, 8'h02);
      for (int a = 0; a < 4; a++) wr(8'(8'h44 + a), a[0] ? 8'hFF : 8'hFE);
      {i_sec_split, i_pri_split} = 2'h3;
      repeat (3) @(negedge i_clk);
      i_pri_split = 1'b0;
      @(negedge i_clk);
      i_sec_split = 1'b0;
      for (int a = 0; a < 4; a++) rd(8'(8'h44 + a), (a == 0) ? 8'h02 : (a == 2) ? 8'h01 : 8'h00);
      for (int k = 0; k < 16; k++) begin
         wr(8'h48, {5'h01, k[2], 2'h0});
         wr(8'h4A, 8'(k));
         {i_fbb_cycle, i_wbuf_full} = k[1:0];
         @(negedge i_clk);
         cmp({3'h0, o_fbb_retry, o_clock_out_on}, {3'h0, &k[2:0], 4'(k)}, "retry and clocks");
      end
      {i_fbb_cycle, i_wbuf_full} = 2'h0;
      wr(8'h48, 8'h08);
      race(8'h08, 8'h08);
      race(8'h09, 8'h01);
      wr(8'h48, 8'h09);
      race(8'h09, 8'h08);
      wr(8'h48, 8'h0A);
      race(8'h11, 8'h10);
      race(8'h81, 8'h80);
      wr(8'h49, 8'h0D);
      wr(8'h48, 8'h0B);
      race(8'h08, 8'h08);
      race(8'h09, 8'h01);
      want = 7'h01;
      wr(8'h43, 8'h00);
      repeat (4) @(negedge i_clk);
      cmp({o_bridge_master_gnt, ~o_gnt_n}, 8'h80, "disabled");
      wr(8'h43, 8'h80);
      repeat (4) @(negedge i_clk);
      race(8'h01, 8'h01);
      test_done();
   end
endmodule : sec_arb_ctrl_bench
